/* File: hdl/pfr_top.sv */
// program flash self-read sequencer
// Functional notes
// [RQ1] erase rows of 32 words, low bits zero
// [RQ2] 32 write latches on row boundary
// [RQ3] requester loads address pair first
// [RQ4] requester clears configuration space select
// [RQ5] requester sets program space select
// [RQ6] requester sets read strobe last
// [RQ7] second cycle after strobe does fetch
// [RQ8] second instruction after strobe is suppressed
// [RQ9] word lands in data pair next cycle
// [RQ10] data pair holds until read or write
// [RQ11] software puts two nops after strobe
// [RQ12] reads ignore code protection setting
// [RQ13] 14-bit word split high and low
// [RQ14] unused high data bits read zero; a software write of the high byte keeps bits 7:6 as written
`timescale 1ns/1ps
module pfr_top
   import pfr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // address pair and control bits from the core
   input wire logic [7:0] mem_addr_high,
   input wire logic [7:0] mem_addr_low,
   input wire logic config_space_select,
   input wire logic program_space_select,
   input wire logic read_strobe_set,
   input wire logic code_protect_setting,
   // software writes to the data pair
   input wire logic data_high_we,
   input wire logic data_low_we,
   input wire logic [7:0] data_wr,
   // write latch load
   input wire logic latch_we,
   input wire logic [PFR_WORD_W-1:0] latch_data,
   // results
   output logic [7:0] mem_data_high,
   output logic [7:0] mem_data_low,
   output logic read_busy,
   output logic instr_suppress,
   output logic [PFR_ROW_LSB_W-1:0] row_offset
);
   typedef struct packed {
      pfr_state_t state;
      logic [7:0] data_high;
      logic [7:0] data_low;
      logic busy;
      logic suppress;
      logic [PFR_ROW_LSB_W-1:0] offset;
   } pfr_regs_t;

   pfr_regs_t r;
   pfr_regs_t next_r;
   logic [PFR_WORD_W-1:0] fetched;
   logic start;
   logic mem_rd;

   function automatic logic [PFR_ROW_LSB_W-1:0] row_off(
      input logic [7:0] lo);
      row_off = lo[PFR_ROW_LSB_W-1:0];
   endfunction

   // protection deliberately not consulted for self reads [RQ12]
   assign start = read_strobe_set && program_space_select &&
      !config_space_select && (r.state == PFR_IDLE); // [RQ4] [RQ5] [RQ6]
   // array read fires on the skip slot, data captured the cycle after
   assign mem_rd = (r.state == PFR_SKIP); // [RQ7]

   pfr_mem u_mem (
      .clk(clk),
      .rd_en(mem_rd),
      .rd_addr({mem_addr_high[2:0], mem_addr_low}), // [RQ3]
      .rd_data(fetched),
      .latch_we(latch_we),
      .latch_idx(row_off(mem_addr_low)), // [RQ2]
      .latch_data(latch_data)
   );

   always_comb begin
      next_r = r;
      next_r.offset = row_off(mem_addr_low); // [RQ1]
      next_r.suppress = 1'b0;
      unique case (r.state)
         PFR_IDLE: begin
            if (start) begin
               next_r.state = PFR_SKIP;
               next_r.busy = 1'b1;
            end
         end
         PFR_SKIP: begin
            // the slot the fetch steals from the core [RQ8]
            next_r.state = PFR_FETCH;
            next_r.suppress = 1'b1;
         end
         PFR_FETCH: begin
            next_r.state = PFR_IDLE;
            next_r.busy = 1'b0;
            next_r.data_high = {2'b00, fetched[PFR_WORD_W-1:8]}; // [RQ13] [RQ14]
            next_r.data_low = fetched[7:0]; // [RQ9]
         end
      endcase
      // software write only lands outside a fetch; read result wins [RQ10]
      if (r.state != PFR_FETCH) begin
         if (data_high_we) begin
            next_r.data_high = data_wr;
         end
         if (data_low_we) begin
            next_r.data_low = data_wr;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r.state <= PFR_IDLE;
         r.data_high <= PFR_BYTE_RST;
         r.data_low <= PFR_BYTE_RST;
         r.busy <= 1'b0;
         r.suppress <= 1'b0;
         r.offset <= PFR_ROW_BASE;
      end else begin
         r <= next_r;
      end
   end

   assign mem_data_high = r.data_high;
   assign mem_data_low = r.data_low;
   assign read_busy = r.busy;
   assign instr_suppress = r.suppress;
   assign row_offset = r.offset;

   sequence s_start;
      start;
   endsequence
   sequence s_fetch_done;
      ##1 (r.state == PFR_SKIP) ##1 (r.state == PFR_FETCH) ##1 !read_busy;
   endsequence

   property p_fetch_slot;
      @(posedge clk) disable iff (reset) s_start |-> s_fetch_done;
   endproperty
   a_fetch_slot: assert property (p_fetch_slot) // [RQ7]
      else $error("fetch did not take the second cycle");

   property p_suppress;
      @(posedge clk) disable iff (reset)
         start |-> !instr_suppress ##1 !instr_suppress ##1 instr_suppress
            ##1 !instr_suppress;
   endproperty
   a_suppress: assert property (p_suppress) // [RQ8]
      else $error("wrong instruction slot suppressed");

   property p_data_low;
      @(posedge clk) disable iff (reset)
         (r.state == PFR_FETCH) |=> mem_data_low == $past(fetched[7:0]);
   endproperty
   a_data_low: assert property (p_data_low) // [RQ9]
      else $error("low data byte not loaded after fetch");

   property p_data_high;
      @(posedge clk) disable iff (reset)
         (r.state == PFR_FETCH) |=>
            mem_data_high[5:0] == $past(fetched[13:8]); // [RQ13]
   endproperty
   a_data_high: assert property (p_data_high) // [RQ13]
      else $error("high data byte not loaded after fetch");

   property p_high_zero;
      @(posedge clk) disable iff (reset)
         (r.state == PFR_FETCH) |=> mem_data_high[7:6] == 2'b00;
   endproperty
   a_high_zero: assert property (p_high_zero) // [RQ14]
      else $error("unused high data bits not zero");

   property p_hold;
      @(posedge clk) disable iff (reset)
         (r.state != PFR_FETCH && !data_high_we && !data_low_we) |=>
            $stable(mem_data_high) && $stable(mem_data_low);
   endproperty
   a_hold: assert property (p_hold) // [RQ10]
      else $error("data pair changed without read or write");

   property p_cp_ignored;
      @(posedge clk) disable iff (reset)
         (read_strobe_set && program_space_select && !config_space_select
            && r.state == PFR_IDLE && code_protect_setting) |=> read_busy;
   endproperty
   a_cp_ignored: assert property (p_cp_ignored) // [RQ12]
      else $error("read blocked by code protection");

   property p_row_offset;
      @(posedge clk) disable iff (reset)
         1'b1 |=> row_offset == $past(mem_addr_low[4:0]);
   endproperty
   a_row_offset: assert property (p_row_offset) // [RQ1]
      else $error("row offset not tracking low address bits");

   property p_busy_len;
      @(posedge clk) disable iff (reset)
         start |=> read_busy ##1 read_busy ##1 !read_busy;
   endproperty
   a_busy_len: assert property (p_busy_len) // [RQ7]
      else $error("busy not high for exactly two cycles");

   // a strobe with the wrong space selected must not start a fetch
   property p_refuse_sel;
      @(posedge clk) disable iff (reset)
         (read_strobe_set && r.state == PFR_IDLE &&
            (config_space_select || !program_space_select)) |=> !read_busy;
   endproperty
   a_refuse_sel: assert property (p_refuse_sel) // [RQ4] [RQ5]
      else $error("read started with wrong space selected");

   // a strobe during the fetch must not restart or stretch it
   property p_refuse_busy;
      @(posedge clk) disable iff (reset)
         (read_strobe_set && r.state == PFR_SKIP) |=>
            (r.state == PFR_FETCH) ##1 (r.state == PFR_IDLE) ##1 !read_busy;
   endproperty
   a_refuse_busy: assert property (p_refuse_busy) // [RQ7]
      else $error("strobe during fetch was not ignored");

   property p_suppress_src;
      @(posedge clk) disable iff (reset)
         instr_suppress |-> $past(mem_rd) && !$past(instr_suppress);
   endproperty
   a_suppress_src: assert property (p_suppress_src) // [RQ8]
      else $error("slot suppressed outside a fetch");
endmodule

/* File: hdl/pfr_pkg.sv */
// package: constants for the program flash self-read block
package pfr_pkg;
   localparam int PFR_ADDR_W = 15;
   localparam int PFR_WORD_W = 14;
   localparam int PFR_DEPTH = 2048;
   localparam int PFR_MEM_AW = 11;
   localparam int PFR_ROW_WORDS = 32;
   localparam int PFR_ROW_LSB_W = 5;
   localparam int PFR_LATCHES = 32;
   localparam int PFR_HI_W = PFR_WORD_W - 8;
   localparam logic [4:0] PFR_ROW_BASE = 5'h00;
   localparam logic [7:0] PFR_BYTE_RST = 8'h00;
   localparam logic [13:0] PFR_WORD_RST = 14'h0000;
   typedef enum logic [2:0] {
      PFR_IDLE = 3'b001,
      PFR_SKIP = 3'b010,
      PFR_FETCH = 3'b100
   } pfr_state_t;
endpackage

/* File: hdl/pfr_mem.sv */
// program flash array with registered read data and row write latches
`timescale 1ns/1ps
module pfr_mem
   import pfr_pkg::*;
(
   // clock
   input wire logic clk,
   // read port
   input wire logic rd_en,
   input wire logic [PFR_MEM_AW-1:0] rd_addr,
   output logic [PFR_WORD_W-1:0] rd_data,
   // write latch load (array programming lives elsewhere)
   input wire logic latch_we,
   input wire logic [PFR_ROW_LSB_W-1:0] latch_idx,
   input wire logic [PFR_WORD_W-1:0] latch_data
);
   logic [PFR_WORD_W-1:0] array [PFR_DEPTH];
   logic [PFR_WORD_W-1:0] latches [PFR_LATCHES];

   initial begin
      for (int i = 0; i < PFR_DEPTH; i++) begin
         array[i] = PFR_WORD_RST;
      end
   end

   always_ff @(posedge clk) begin
      if (rd_en) begin
         rd_data <= array[rd_addr];
      end
   end

   // one latch per row word, indexed by the low address bits [RQ2]
   always_ff @(posedge clk) begin
      if (latch_we) begin
         latches[latch_idx] <= latch_data;
      end
   end
endmodule

/* File: dv/pfr_cpu.sv */
// core model that runs the self-read sequence and data pair writes
`timescale 1ns/1ps
module pfr_cpu (
   // clock
   input wire logic clk,
   // control toward the sequencer
   output logic [7:0] mem_addr_high,
   output logic [7:0] mem_addr_low,
   output logic config_space_select,
   output logic program_space_select,
   output logic read_strobe_set,
   output logic code_protect_setting,
   // data pair writes and latch loads
   output logic data_high_we,
   output logic data_low_we,
   output logic [7:0] data_wr,
   output logic latch_we,
   output logic [13:0] latch_data
);
   initial begin
      {mem_addr_high, mem_addr_low, data_wr} = 24'h000000;
      {config_space_select, program_space_select} = 2'h0;
      {read_strobe_set, code_protect_setting, latch_we} = 3'h0;
      {data_high_we, data_low_we, latch_data} = 16'h0000;
   end
   // strobe comes last, one cycle, then the slot stays empty
   task automatic start(input logic [15:0] a, input logic c, p, k);
      @(negedge clk);
      {mem_addr_high, mem_addr_low} = a;
      config_space_select = c;
      program_space_select = p;
      code_protect_setting = k;
      @(negedge clk);
      read_strobe_set = 1'b1;
      @(negedge clk);
      read_strobe_set = 1'b0;
   endtask
   task automatic wr(input logic [7:0] h, l);
      @(negedge clk);
      {data_high_we, data_wr} = {1'b1, h};
      @(negedge clk);
      {data_high_we, data_low_we, data_wr} = {2'b01, l};
      @(negedge clk);
      data_low_we = 1'b0;
   endtask
endmodule

/* File: dv/pfr_top_test.sv */
// self-checking bench for the program flash self-read sequencer
`timescale 1ns/1ps
module pfr_top_test;
   import pfr_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] ah, al, dw, dh, dl, eh, el;
   logic cs, ps, st, cp, hw, lw, lt, bz, sp, go;
   logic [13:0] ld;
   logic [4:0] ro;
   int errors = 0;
   int checked = 0;
   always #25 clk = ~clk;
   pfr_cpu cpu (.clk(clk), .mem_addr_high(ah), .mem_addr_low(al),
      .config_space_select(cs), .program_space_select(ps),
      .read_strobe_set(st), .code_protect_setting(cp),
      .data_high_we(hw), .data_low_we(lw), .data_wr(dw),
      .latch_we(lt), .latch_data(ld));
   pfr_top dut (.clk(clk), .reset(reset), .mem_addr_high(ah),
      .mem_addr_low(al), .config_space_select(cs),
      .program_space_select(ps), .read_strobe_set(st),
      .code_protect_setting(cp), .data_high_we(hw), .data_low_we(lw),
      .data_wr(dw), .latch_we(lt), .latch_data(ld),
      .mem_data_high(dh), .mem_data_low(dl), .read_busy(bz),
      .instr_suppress(sp), .row_offset(ro));
   task automatic cmp8(input logic [7:0] g, e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: byte %h not %h", $time, g, e);
      end
   endtask
   task automatic cmp_fl(input logic [1:0] g, e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: busy/skip %b not %b", $time, g, e);
      end
   endtask
   // returns in cycle 3, after the data pair should have settled
   task automatic rd(input logic [15:0] a, input logic c, p, k);
      logic [13:0] w;
      // preload a distinct word so both data bytes carry content
      w = a[13:0] ^ 14'h2d5a;
      dut.u_mem.array[a[10:0]] = w;
      go = p & ~c;
      cpu.start(a, c, p, k);
      cmp8({3'h0, ro}, a[7:0] & 8'h1f);
      cmp_fl({bz, sp}, {go, 1'b0});
      @(negedge clk);
      cmp_fl({bz, sp}, {go, go});
      @(negedge clk);
      cmp_fl({bz, sp}, 2'b00);
      if (go) {eh, el} = {2'b00, w};
      cmp8(dh, eh);
      cmp8(dl, el);
      // address no longer held: show its inverse
      {cpu.mem_addr_high, cpu.mem_addr_low} = ~a;
   endtask
   task automatic end_of_test();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      cmp8(dh, 8'h00);
      cmp8(dl, 8'h00);
      cmp8({3'h0, ro}, 8'h00);
      cmp_fl({bz, sp}, 2'b00);
      // every select combination, with protection on and off
      for (int i = 0; i < 8; i++) begin
         eh = 8'h10 + 8'(i);
         el = 8'ha0 + 8'(i);
         cpu.wr(eh, el);
         rd(16'h07e0 + 16'(i * 5), i[2], i[1], i[0]);
      end
      // strobe held into the busy slot is dropped, busy ends on time
      @(negedge clk);
      {cpu.mem_addr_high, cpu.mem_addr_low} = 16'h0020;
      {cpu.config_space_select, cpu.program_space_select} = 2'b01;
      @(negedge clk);
      cpu.read_strobe_set = 1'b1;
      repeat (2) @(negedge clk);
      cpu.read_strobe_set = 1'b0;
      cmp_fl({bz, sp}, 2'b11);
      @(negedge clk);
      cmp_fl({bz, sp}, 2'b00);
      cmp8(dh, 8'h00);
      cmp8(dl, 8'h00);
      cpu.latch_data = 14'h2abc;
      cpu.latch_we = 1'b1;
      @(negedge clk);
      cpu.latch_we = 1'b0;
      rd(16'h001f, 1'b0, 1'b1, 1'b1);
      end_of_test();
   end
   initial begin
      #50000;
      errors++;
      end_of_test();
   end
endmodule
